// ==== core/rtcsch_pkg.sv ====
// Constants and types for the schedule programming and validation block
package rtcsch_pkg;
   // ---------------------------------------------------------------
   // Register pages and offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] PAGE_COMMON = 8'h6b;
   localparam logic [7:0] PAGE_START = 8'h6c;
   localparam logic [7:0] PAGE_RUN = 8'h6d;
   localparam logic [7:0] OFF_SCHEDULE_SELECT = 8'h16;
   localparam logic [7:0] OFF_SCHEDULER_RUN = 8'h17;
   localparam logic [7:0] OFF_ACTIVE = 8'h00;
   localparam logic [7:0] OFF_MINUTE = 8'h01;
   localparam logic [7:0] OFF_HOUR = 8'h02;
   localparam logic [7:0] OFF_MDAY = 8'h03;
   localparam logic [7:0] OFF_MONTH = 8'h04;
   localparam logic [7:0] OFF_YEAR = 8'h05;
   localparam logic [7:0] OFF_ACTION_RUN_MINUTES = 8'h00;
   localparam logic [7:0] OFF_ACTION_PERIOD_MINUTES = 8'h02;
   localparam logic [7:0] OFF_ACTION_REPEAT_COUNT = 8'h03;
   localparam logic [7:0] OFF_SEQUENCE_PERIOD_HOURS = 8'h04;
   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_ACTION_RUN_MINUTES = 16'h0001;
   localparam logic [7:0] RST_ACTION_PERIOD_MINUTES = 8'h00;
   localparam logic [7:0] RST_ACTION_REPEAT_COUNT = 8'h00;
   localparam logic [7:0] RST_SEQUENCE_PERIOD_HOURS = 8'h18;
   localparam logic [7:0] RST_START_FIELD = 8'h00;
   localparam logic [7:0] RST_MDAY = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] ACTIVE_OFF = 8'h00;
   localparam logic [7:0] ACTIVE_ALT = 8'h01;
   localparam logic [7:0] ACTIVE_ON = 8'hff;
   localparam logic [7:0] RUN_OFF = 8'h00;
   localparam logic [7:0] RUN_ON = 8'h01;
   localparam logic [7:0] MAX_SELECT = 8'h03;
   localparam logic [7:0] BCD_MIN_MDAY = 8'h01;
   localparam logic [7:0] BCD_MAX_MDAY = 8'h31;
   localparam logic [7:0] BCD_MAX_HOUR = 8'h23;
   localparam logic [7:0] BCD_MAX_MINUTE = 8'h59;
   localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
   localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
   localparam logic [7:0] BCD_FEB = 8'h02;
   localparam logic [7:0] BCD_DAY_28 = 8'h28;
   localparam logic [7:0] BCD_DAY_29 = 8'h29;
   localparam logic [7:0] BCD_DAY_30 = 8'h30;
   localparam logic [15:0] MAX_RUN_MINUTES = 16'h059f; // 1439
   localparam logic [15:0] RUN_SPECIAL = 16'hffff;
   localparam logic [7:0] MAX_SEQ_HOURS = 8'h18; // 24
   localparam logic [7:0] MINUTES_PER_HOUR = 8'h3c; // 60
   // ---------------------------------------------------------------
   // Feedback timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 1_000_000; // 1 ms feedback tick
   localparam logic [11:0] SLOT_MS = 12'h0c8; // 200 ms LED slot
   localparam logic [11:0] BEEP_SHORT_MS = 12'h064; // 100 ms
   localparam logic [11:0] BEEP_LONG_MS = 12'h3e8; // 1000 ms
   localparam logic [3:0] SLOTS_OK = 4'h1; // one blink
   localparam logic [3:0] SLOTS_ERR = 4'h9; // five blinks
   localparam int BAUD = 38400;
   localparam logic [10:0] BAUD_CYCLES = 11'(1_000_000_000 / (BAUD * CLK_NS));
   localparam logic [7:0] MSG_OK = 8'h41; // 'A'
   localparam logic [7:0] MSG_ERR = 8'h45; // 'E'
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      RTCSCH_FB_IDLE = 3'b001,
      RTCSCH_FB_OK = 3'b010,
      RTCSCH_FB_ERR = 3'b100
   } rtcsch_fb_t;

   typedef struct packed {
      logic [7:0] active;
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] mday;
      logic [7:0] month;
      logic [7:0] year;
      logic [15:0] action_run_minutes;
      logic [7:0] action_period_minutes;
      logic [7:0] action_repeat_count;
      logic [7:0] sequence_period_hours;
   } rtcsch_sched_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] page;
      logic [7:0] offset;
      logic [15:0] wdata;
   } rtcsch_req_t;

   typedef struct packed {
      logic [3:0] [0:0] pad;
      rtcsch_sched_t [3:0] sch;
      logic [1:0] schedule_select;
      logic scheduler_run;
      logic [15:0] rdata;
      logic rvalid;
      logic entry_done;
      logic entry_ok;
      rtcsch_fb_t fb;
      logic [15:0] tick_cnt;
      logic [11:0] slot_ms;
      logic [11:0] elapsed_ms;
      logic [3:0] slot_idx;
      logic [9:0] tx_shift;
      logic [3:0] tx_bits;
      logic [10:0] baud_cnt;
      logic tx_pend;
      logic [7:0] tx_pend_byte;
   } rtcsch_state_t;
endpackage

// ==== core/rtcsch_core.sv ====
// Schedule register file with entry checks, LED/beeper and serial feedback
`timescale 1ns/10ps
module rtcsch_core #(
   parameter int TICK_CYCLES = rtcsch_pkg::TICK_NS / rtcsch_pkg::CLK_NS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register access, one byte or word per strobe
   input wire rtcsch_pkg::rtcsch_req_t req,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic entry_done,
   output logic entry_ok,
   // Feedback
   output logic [2:0] user_led,
   output logic beeper,
   output logic uart_tx,
   // Schedule state towards the execution engine
   output logic scheduler_run,
   output logic [3:0] schedule_active,
   output logic [3:0] repeat_enable
);
   rtcsch_pkg::rtcsch_state_t q;
   rtcsch_pkg::rtcsch_state_t next_q;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Both digits decimal and within an upper bound
   function automatic logic bcd_le(input logic [7:0] v,
                                   input logic [7:0] lim);
      bcd_le = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v <= lim);
   endfunction
   // Last day of a month in BCD; years are 2000..2099
   function automatic logic [7:0] month_last_day(input logic [7:0] mon,
                                                 input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      if (mon == rtcsch_pkg::BCD_FEB) begin
         month_last_day = leap ? rtcsch_pkg::BCD_DAY_29
                               : rtcsch_pkg::BCD_DAY_28;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                   mon == 8'h11) begin
         month_last_day = rtcsch_pkg::BCD_DAY_30;
      end else begin
         month_last_day = rtcsch_pkg::BCD_MAX_MDAY;
      end
   endfunction
   // Timing check widened so no sum or product wraps; 0xffff skips it
   function automatic logic timing_ok(input rtcsch_pkg::rtcsch_sched_t s);
      logic [19:0] busy_min;
      logic [15:0] seq_min;
      busy_min = (20'(s.action_run_minutes) +
                  20'(s.action_period_minutes)) *
                 20'(s.action_repeat_count);
      seq_min = 16'(s.sequence_period_hours) *
                16'(rtcsch_pkg::MINUTES_PER_HOUR);
      timing_ok = (s.action_run_minutes == rtcsch_pkg::RUN_SPECIAL) ||
                  (busy_min < 20'(seq_min));
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      rtcsch_pkg::rtcsch_sched_t cand;
      logic hit;
      logic ok;
      logic [7:0] b;
      logic tick;
      next_q = q;
      cand = q.sch[q.schedule_select];
      hit = req.wr;
      ok = 1'b0;
      b = req.wdata[7:0];
      tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
      next_q.rvalid = 1'b0;
      // Register writes: every field checked before it is stored
      if (req.wr) begin
         unique case (req.page)
            rtcsch_pkg::PAGE_COMMON: begin
               if (req.offset == rtcsch_pkg::OFF_SCHEDULE_SELECT) begin
                  ok = (b <= rtcsch_pkg::MAX_SELECT);
                  if (ok) next_q.schedule_select = b[1:0];
               end else if (req.offset == rtcsch_pkg::OFF_SCHEDULER_RUN) begin
                  ok = (b == rtcsch_pkg::RUN_OFF) ||
                       (b == rtcsch_pkg::RUN_ON);
                  if (ok) next_q.scheduler_run = b[0];
               end else begin
                  hit = 1'b0;
               end
            end
            rtcsch_pkg::PAGE_START: begin
               unique case (req.offset)
                  rtcsch_pkg::OFF_ACTIVE: begin
                     ok = (b == rtcsch_pkg::ACTIVE_OFF) ||
                          (b == rtcsch_pkg::ACTIVE_ON) ||
                          (b == rtcsch_pkg::ACTIVE_ALT);
                     cand.active = b;
                  end
                  rtcsch_pkg::OFF_MINUTE: begin
                     ok = bcd_le(b, rtcsch_pkg::BCD_MAX_MINUTE);
                     cand.minute = b;
                  end
                  rtcsch_pkg::OFF_HOUR: begin
                     ok = bcd_le(b, rtcsch_pkg::BCD_MAX_HOUR);
                     cand.hour = b;
                  end
                  rtcsch_pkg::OFF_MDAY: begin
                     ok = bcd_le(b, month_last_day(cand.month, cand.year))
                          && (b >= rtcsch_pkg::BCD_MIN_MDAY);
                     cand.mday = b;
                  end
                  rtcsch_pkg::OFF_MONTH: begin
                     ok = bcd_le(b, rtcsch_pkg::BCD_MAX_MONTH) && (b != 8'h00);
                     cand.month = b;
                  end
                  rtcsch_pkg::OFF_YEAR: begin
                     ok = bcd_le(b, rtcsch_pkg::BCD_MAX_YEAR);
                     cand.year = b;
                  end
                  default: hit = 1'b0;
               endcase
            end
            rtcsch_pkg::PAGE_RUN: begin
               ok = 1'b1;
               unique case (req.offset)
                  rtcsch_pkg::OFF_ACTION_RUN_MINUTES: begin
                     cand.action_run_minutes = req.wdata;
                     ok = (req.wdata == rtcsch_pkg::RUN_SPECIAL) ||
                          ((req.wdata != 16'h0000) &&
                           (req.wdata <= rtcsch_pkg::MAX_RUN_MINUTES));
                  end
                  rtcsch_pkg::OFF_ACTION_PERIOD_MINUTES:
                     cand.action_period_minutes = b;
                  rtcsch_pkg::OFF_ACTION_REPEAT_COUNT:
                     cand.action_repeat_count = b;
                  rtcsch_pkg::OFF_SEQUENCE_PERIOD_HOURS: begin
                     cand.sequence_period_hours = b;
                     ok = (|b) && (b <= rtcsch_pkg::MAX_SEQ_HOURS);
                  end
                  default: hit = 1'b0;
               endcase
               ok = ok && timing_ok(cand);
            end
            default: hit = 1'b0;
         endcase
         // Rejected data never lands, old contents stay
         if (hit && ok && req.page != rtcsch_pkg::PAGE_COMMON) begin
            next_q.sch[q.schedule_select] = cand;
         end
      end
      next_q.entry_done = hit;
      if (hit) next_q.entry_ok = ok;
      // Feedback pattern restarts on every entry; newest outcome wins
      next_q.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
      if (hit) begin
         next_q.fb = ok ? rtcsch_pkg::RTCSCH_FB_OK
                        : rtcsch_pkg::RTCSCH_FB_ERR;
         next_q.tick_cnt = 16'h0000;
         next_q.slot_ms = 12'h000;
         next_q.elapsed_ms = 12'h000;
         next_q.slot_idx = 4'h0;
      end else if (tick && q.fb != rtcsch_pkg::RTCSCH_FB_IDLE) begin
         next_q.elapsed_ms = q.elapsed_ms + 12'h001;
         if (q.slot_ms == rtcsch_pkg::SLOT_MS - 12'h001) begin
            next_q.slot_ms = 12'h000;
            next_q.slot_idx = q.slot_idx + 4'h1;
            if (q.slot_idx + 4'h1 ==
                ((q.fb == rtcsch_pkg::RTCSCH_FB_OK) ? rtcsch_pkg::SLOTS_OK
                                                    : rtcsch_pkg::SLOTS_ERR))
               next_q.fb = rtcsch_pkg::RTCSCH_FB_IDLE;
         end else begin
            next_q.slot_ms = q.slot_ms + 12'h001;
         end
      end
      // Serial report: 8N1, one pending byte behind the one in flight
      if (hit) begin
         next_q.tx_pend = 1'b1;
         next_q.tx_pend_byte = ok ? rtcsch_pkg::MSG_OK : rtcsch_pkg::MSG_ERR;
      end
      if (q.tx_bits != 4'h0) begin
         if (q.baud_cnt == rtcsch_pkg::BAUD_CYCLES - 11'h001) begin
            next_q.baud_cnt = 11'h000;
            next_q.tx_shift = {1'b1, q.tx_shift[9:1]};
            next_q.tx_bits = q.tx_bits - 4'h1;
         end else begin
            next_q.baud_cnt = q.baud_cnt + 11'h001;
         end
      end else if (q.tx_pend) begin
         next_q.tx_shift = {1'b1, q.tx_pend_byte, 1'b0};
         next_q.tx_bits = 4'ha;
         next_q.baud_cnt = 11'h000;
         next_q.tx_pend = hit; // A fresh outcome this cycle stays queued
      end
      // Register reads of the selected schedule
      if (req.rd) begin
         next_q.rvalid = 1'b1;
         next_q.rdata = 16'h0000;
         if (req.page == rtcsch_pkg::PAGE_COMMON) begin
            if (req.offset == rtcsch_pkg::OFF_SCHEDULE_SELECT)
               next_q.rdata = {14'h0000, q.schedule_select};
            else if (req.offset == rtcsch_pkg::OFF_SCHEDULER_RUN)
               next_q.rdata = {15'h0000, q.scheduler_run};
         end else if (req.page == rtcsch_pkg::PAGE_START) begin
            unique case (req.offset)
               rtcsch_pkg::OFF_ACTIVE: next_q.rdata = {8'h00, cand.active};
               rtcsch_pkg::OFF_MINUTE: next_q.rdata = {8'h00, cand.minute};
               rtcsch_pkg::OFF_HOUR: next_q.rdata = {8'h00, cand.hour};
               rtcsch_pkg::OFF_MDAY: next_q.rdata = {8'h00, cand.mday};
               rtcsch_pkg::OFF_MONTH: next_q.rdata = {8'h00, cand.month};
               rtcsch_pkg::OFF_YEAR: next_q.rdata = {8'h00, cand.year};
               default: next_q.rdata = 16'h0000;
            endcase
         end else if (req.page == rtcsch_pkg::PAGE_RUN) begin
            unique case (req.offset)
               rtcsch_pkg::OFF_ACTION_RUN_MINUTES:
                  next_q.rdata = cand.action_run_minutes;
               rtcsch_pkg::OFF_ACTION_PERIOD_MINUTES:
                  next_q.rdata = {8'h00, cand.action_period_minutes};
               rtcsch_pkg::OFF_ACTION_REPEAT_COUNT:
                  next_q.rdata = {8'h00, cand.action_repeat_count};
               rtcsch_pkg::OFF_SEQUENCE_PERIOD_HOURS:
                  next_q.rdata = {8'h00, cand.sequence_period_hours};
               default: next_q.rdata = 16'h0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Synchronous reset to documented defaults
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         q <= '0;
         q.sch <= {4{rtcsch_pkg::ACTIVE_OFF,
                     rtcsch_pkg::RST_START_FIELD, rtcsch_pkg::RST_START_FIELD,
                     rtcsch_pkg::RST_MDAY, rtcsch_pkg::RST_MONTH,
                     rtcsch_pkg::RST_START_FIELD,
                     rtcsch_pkg::RST_ACTION_RUN_MINUTES,
                     rtcsch_pkg::RST_ACTION_PERIOD_MINUTES,
                     rtcsch_pkg::RST_ACTION_REPEAT_COUNT,
                     rtcsch_pkg::RST_SEQUENCE_PERIOD_HOURS}};
         q.fb <= rtcsch_pkg::RTCSCH_FB_IDLE;
         q.tx_shift <= 10'h3ff;
      end else begin
         q <= next_q;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // LEDs lit on even slots, beep length set by outcome
   always_comb begin
      user_led = {3{q.fb != rtcsch_pkg::RTCSCH_FB_IDLE && !q.slot_idx[0]}};
      beeper = (q.fb == rtcsch_pkg::RTCSCH_FB_OK &&
                q.elapsed_ms < rtcsch_pkg::BEEP_SHORT_MS) ||
               (q.fb == rtcsch_pkg::RTCSCH_FB_ERR &&
                q.elapsed_ms < rtcsch_pkg::BEEP_LONG_MS);
      for (int i = 0; i < 4; i++) begin
         schedule_active[i] = (q.sch[i].active != rtcsch_pkg::ACTIVE_OFF);
         repeat_enable[i] = (q.sch[i].action_period_minutes != 8'h00) &&
                            (q.sch[i].action_repeat_count != 8'h00);
      end
   end
   assign uart_tx = q.tx_shift[0];
   assign reg_rdata = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign entry_done = q.entry_done;
   assign entry_ok = q.entry_ok;
   assign scheduler_run = q.scheduler_run;
endmodule // rtcsch_core

// ==== dv/rtcsch_core_sva.sv ====
// Port assertions for the schedule programming block
`timescale 1ns/10ps
module rtcsch_core_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Watched ports
   input wire rtcsch_pkg::rtcsch_req_t req,
   input wire logic entry_done,
   input wire logic entry_ok,
   input wire logic reg_rvalid,
   input wire logic [2:0] user_led,
   input wire logic beeper,
   input wire logic scheduler_run
);
   // Write decodes for the run-time word and the start page
   logic wr_run;
   logic wr_st;
   assign wr_run = req.wr && req.page == 8'h6d && req.offset == 8'h00;
   assign wr_st = req.wr && req.page == 8'h6c;
   // ----
   // Properties
   // ----
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_led_same; user_led == 3'b000 || user_led == 3'b111; endproperty
   a_led_same: assert property (p_led_same) else $error("leds differ");
   property p_done_fb; entry_done |-> user_led == 3'b111 && beeper; endproperty
   a_done_fb: assert property (p_done_fb) else $error("no feedback");
   property p_rd; req.rd |=> reg_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_run_done; wr_run |=> entry_done; endproperty
   a_run_done: assert property (p_run_done) else $error("no entry");
   property p_run_big;
      wr_run && req.wdata > 16'h059f && req.wdata != 16'hffff |=> !entry_ok;
   endproperty
   a_run_big: assert property (p_run_big) else $error("long run kept");
   property p_run_ff; wr_run && req.wdata == 16'hffff |=> entry_ok; endproperty
   a_run_ff: assert property (p_run_ff) else $error("code refused");
   property p_hour;
      wr_st && req.offset == 8'h02 && req.wdata[7:0] > 8'h23
      |=> entry_done && !entry_ok;
   endproperty
   a_hour: assert property (p_hour) else $error("bad hour kept");
   property p_mday;
      wr_st && req.offset == 8'h03
      && (req.wdata[7:0] > 8'h31 || req.wdata[7:0] == 8'h00)
      |=> entry_done && !entry_ok;
   endproperty
   a_mday: assert property (p_mday) else $error("bad day kept");
   property p_run_on;
      $rose(scheduler_run) |-> $past(req.wr) && $past(req.wdata[7:0]) == 8'h01;
   endproperty
   a_run_on: assert property (p_run_on) else $error("run rose alone");
endmodule // rtcsch_core_sva

bind rtcsch_core rtcsch_core_sva i_sva (.mclk(mclk), .reset_n(reset_n),
   .req(req), .entry_done(entry_done), .entry_ok(entry_ok),
   .reg_rvalid(reg_rvalid), .user_led(user_led), .beeper(beeper),
   .scheduler_run(scheduler_run));

// ==== dv/rtcsch_host.sv ====
// Host model issuing register strobes to the schedule block
`timescale 1ns/10ps
module rtcsch_host (
   // Clock
   input wire logic mclk,
   // Request towards the block
   output rtcsch_pkg::rtcsch_req_t req,
   // Answers
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic entry_done,
   input wire logic entry_ok
);
   // Quiet bus at time zero
   initial begin
      req = '0;
   end
   // One write strobe; outcome taken after the taking edge
   task automatic wr(input logic [15:0] at, input logic [15:0] d,
      output logic done, output logic ok);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, at[15:8], at[7:0], d};
      @(posedge mclk);
      // Released fields flip so stale values cannot pass for held ones
      req <= '{1'b0, 1'b0, ~at[15:8], ~at[7:0], ~d};
      #1;
      done = entry_done;
      ok = entry_ok;
   endtask
   // One read strobe, answer taken after the taking edge
   task automatic rd(input logic [15:0] at, output logic [15:0] q,
      output logic v);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, at[15:8], at[7:0], 16'h0000};
      @(posedge mclk);
      req <= '{1'b0, 1'b0, ~at[15:8], ~at[7:0], 16'hffff};
      #1;
      q = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule // rtcsch_host

// ==== dv/tb_rtcsch_core.sv ====
// Self-checking bench for the schedule programming block
`timescale 1ns/10ps
module tb_rtcsch_core;
   typedef struct packed {
      logic [15:0] at;
      logic [15:0] d;
      logic [1:0] fl;
      logic [15:0] rb;
      logic [8:0] st;
   } rtcsch_row_t;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   rtcsch_pkg::rtcsch_req_t req;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic entry_done;
   logic entry_ok;
   logic [2:0] user_led;
   logic beeper;
   logic uart_tx;
   logic scheduler_run;
   logic [3:0] schedule_active;
   logic [3:0] repeat_enable;
   logic done;
   logic ok;
   logic [7:0] rxb;
   int fail_count = 0;
   int compares = 0;
   // Entries: address, data, {done, ok}, read back, {run, active, repeat}
   rtcsch_row_t tab [0:23] = '{
      '{16'h6b16, 16'h0004, 2'b10, 16'h0000, 9'h000},
      '{16'h6b16, 16'h0001, 2'b11, 16'h0001, 9'h000},
      '{16'h6c04, 16'h0002, 2'b11, 16'h0002, 9'h000},
      '{16'h6c05, 16'h0023, 2'b11, 16'h0023, 9'h000},
      '{16'h6c03, 16'h0029, 2'b10, 16'h0001, 9'h000},
      '{16'h6c05, 16'h0024, 2'b11, 16'h0024, 9'h000},
      '{16'h6c03, 16'h0029, 2'b11, 16'h0029, 9'h000},
      '{16'h6c04, 16'h0004, 2'b11, 16'h0004, 9'h000},
      '{16'h6c03, 16'h0031, 2'b10, 16'h0029, 9'h000},
      '{16'h6c03, 16'h0032, 2'b10, 16'h0029, 9'h000},
      '{16'h6c02, 16'h0023, 2'b11, 16'h0023, 9'h000},
      '{16'h6c02, 16'h0024, 2'b10, 16'h0023, 9'h000},
      '{16'h6c01, 16'h0060, 2'b10, 16'h0000, 9'h000},
      '{16'h6d00, 16'h059f, 2'b11, 16'h059f, 9'h000},
      '{16'h6d00, 16'h05a0, 2'b10, 16'h059f, 9'h000},
      '{16'h6d00, 16'hffff, 2'b11, 16'hffff, 9'h000},
      '{16'h6d00, 16'h0001, 2'b11, 16'h0001, 9'h000},
      '{16'h6d02, 16'h0002, 2'b11, 16'h0002, 9'h000},
      '{16'h6d03, 16'h003c, 2'b11, 16'h003c, 9'h002},
      '{16'h6d01, 16'h0005, 2'b01, 16'h0000, 9'h002},
      '{16'h6d04, 16'h0003, 2'b10, 16'h0018, 9'h002},
      '{16'h6d04, 16'h0019, 2'b10, 16'h0018, 9'h002},
      '{16'h6d02, 16'h0000, 2'b11, 16'h0000, 9'h000},
      '{16'h6c00, 16'h00ff, 2'b11, 16'h00ff, 9'h020}};
   // Short millisecond tick keeps the feedback patterns brief
   rtcsch_core #(.TICK_CYCLES(10)) i_dut (.mclk(mclk), .reset_n(reset_n),
      .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .entry_done(entry_done), .entry_ok(entry_ok), .user_led(user_led),
      .beeper(beeper), .uart_tx(uart_tx), .scheduler_run(scheduler_run),
      .schedule_active(schedule_active), .repeat_enable(repeat_enable));
   rtcsch_host i_host (.mclk(mclk), .req(req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .entry_done(entry_done), .entry_ok(entry_ok));
   // 50 MHz clock
   initial begin
      forever #10 mclk = ~mclk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read with answer check
   task automatic rchk(input logic [15:0] at, input logic [15:0] e);
      logic [15:0] q;
      logic v;
      i_host.rd(at, q, v);
      chk("read valid", 16'h0001, {15'h0, v});
      chk("read data", e, q);
   endtask
   // Serial byte catch, mid-bit on falling edges where the line is settled
   task automatic rx(output logic [7:0] b);
      int n;
      n = 0;
      while (uart_tx !== 1'b0 && n < 4000) begin
         @(negedge mclk);
         n++;
      end
      repeat (rtcsch_pkg::BAUD_CYCLES * 3 / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         b[i] = uart_tx;
         repeat (rtcsch_pkg::BAUD_CYCLES) @(negedge mclk);
      end
   endtask
   task automatic finish_test;
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run of some 46k cycles
   initial begin
      #1_500_000;
      fail_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rchk(16'h6d00, 16'h0001);
      rchk(16'h6d02, 16'h0000);
      rchk(16'h6d03, 16'h0000);
      rchk(16'h6d04, 16'h0018);
      rchk(16'h6b17, 16'h0000);
      i_host.wr(16'h6b16, 16'h0000, done, ok);
      rx(rxb);
      chk("accept byte", {8'h00, rtcsch_pkg::MSG_OK}, {8'h00, rxb});
      i_host.wr(16'h6b16, 16'h0004, done, ok);
      rx(rxb);
      chk("reject byte", {8'h00, rtcsch_pkg::MSG_ERR}, {8'h00, rxb});
      // Reject pattern: blink slots, then long beep ends
      i_host.wr(16'h6b17, 16'h0002, done, ok);
      repeat (2900) @(posedge mclk);
      chk("err led off", 16'h0000, {13'h0, user_led});
      repeat (2000) @(posedge mclk);
      chk("err led on", 16'h0007, {13'h0, user_led});
      repeat (5000) @(posedge mclk);
      chk("long beep", 16'h0001, {15'h0, beeper});
      repeat (8200) @(posedge mclk);
      chk("err end", 16'h0000, {12'h0, beeper, user_led});
      // Accept pattern: one blink, short beep
      i_host.wr(16'h6b16, 16'h0000, done, ok);
      repeat (1900) @(posedge mclk);
      chk("ok led", 16'h0007, {12'h0, beeper, user_led});
      repeat (200) @(posedge mclk);
      chk("ok end", 16'h0000, {13'h0, user_led});
      foreach (tab[i]) begin
         i_host.wr(tab[i].at, tab[i].d, done, ok);
         chk("entry", {14'h0, tab[i].fl}, {14'h0, done, ok});
         rchk(tab[i].at, tab[i].rb);
         chk("state", {7'h0, tab[i].st},
            {7'h0, scheduler_run, schedule_active, repeat_enable});
      end
      i_host.wr(16'h6b17, 16'h0001, done, ok);
      chk("run on", 16'h0001, {15'h0, scheduler_run});
      finish_test();
   end
endmodule // tb_rtcsch_core
